//--- design/gceq_filter.sv
`timescale 1ns/1ns
module gceq_filter (
   input  wire logic                        i_clk,
   input  wire logic                        i_reset_n,
   // Sample input from the separation filter.
   input  wire logic                        i_valid,
   output logic                             o_ready,
   input  wire logic signed [15:0]          i_left,
   input  wire logic signed [15:0]          i_right,
   // Sample output toward level control.
   output logic                             o_valid,
   input  wire logic                        i_ready,
   output logic signed [15:0]               o_left,
   output logic signed [15:0]               o_right,
   // Control bits.
   input  wire logic                        i_comp_eq_enable,
   input  wire logic [15:0]                 i_comp_coef_a,
   input  wire logic [13:0]                 i_comp_coef_b,
   input  wire logic [15:0]                 i_comp_coef_c,
   input  wire logic [1:0]                  i_fixed_gain_select,
   input  wire logic [4:0]                  i_band_enable,
   input  wire logic [4:0][15:0]            i_band_coef_a,
   input  wire logic [4:0][15:0]            i_band_coef_b,
   input  wire logic [4:0][15:0]            i_band_coef_c,
   input  wire logic                        i_left_adc_power,
   input  wire logic                        i_right_adc_power,
   input  wire logic                        i_playback_filter_select,
   output logic                             o_recording_path,
   output logic                             o_busy
);
   localparam int AW = gceq_pkg::ACC_W;
   localparam int FB = gceq_pkg::FRAC_BITS;

   //==============================================================
   // Helpers.
   //==============================================================
   function automatic logic signed [AW-1:0] sat16(input logic signed [AW-1:0] v);
      if (v > 40'sh0000007fff) begin
         return 40'sh0000007fff;
      end else if (v < -40'sh0000008000) begin
         return -40'sh0000008000;
      end
      return v;
   endfunction : sat16

   function automatic logic signed [AW-1:0] mulq(input logic signed [AW-1:0] x,
                                                 input logic signed [15:0]   c);
      logic signed [AW+15:0] p;
      p = x * c;
      return AW'(p >>> FB);
   endfunction : mulq

   function automatic logic signed [AW-1:0] sext16(
      input logic [15:0] v
   );
      return AW'($signed(v));
   endfunction : sext16

   function automatic logic [15:0] clip16(
      input logic signed [AW-1:0] v
   );
      logic signed [AW-1:0] s;
      s = sat16(v);
      return s[15:0];
   endfunction : clip16

   function automatic int gain_shift(
      input logic [1:0] sel
   );
      int sh;
      sh = 0;
      case (sel)
         gceq_pkg::GAIN_0DB: begin
            sh = 0;
         end
         gceq_pkg::GAIN_12DB: begin
            sh = gceq_pkg::SHIFT_12DB;
         end
         default: begin
            sh = gceq_pkg::SHIFT_24DB;
         end
      endcase
      return sh;
   endfunction : gain_shift

   function automatic logic signed [AW-1:0] apply_gain(
      input logic signed [AW-1:0] v,
      input logic [1:0]           sel
   );
      return v <<< gain_shift(sel);
   endfunction : apply_gain

   function automatic logic signed [AW-1:0] comp_step(
      input logic signed [AW-1:0] x,
      input logic signed [AW-1:0] x1,
      input logic signed [AW-1:0] y1,
      input logic [15:0]          a,
      input logic [13:0]          b,
      input logic [15:0]          c
   );
      logic signed [15:0] bw;
      bw = {{2{b[13]}}, b};
      return mulq(x, a) + mulq(x1, c) - mulq(y1, bw);
   endfunction : comp_step

   function automatic logic signed [AW-1:0] band_step(
      input logic signed [AW-1:0] x,
      input logic signed [AW-1:0] x2,
      input logic signed [AW-1:0] y1,
      input logic signed [AW-1:0] y2,
      input logic [15:0]          a,
      input logic [15:0]          b,
      input logic [15:0]          c
   );
      return mulq(x - x2, a) + mulq(y1, b) + mulq(y2, c);
   endfunction : band_step

   function automatic logic record_path(
      input logic playback_sel,
      input logic left_power,
      input logic right_power
   );
      return !playback_sel && (left_power || right_power);
   endfunction : record_path

   //==============================================================
   // State.
   //==============================================================
   typedef struct packed {
      gceq_pkg::gceq_state_t       fsm;
      logic                        ch;
      logic [2:0]                  band;
      logic signed [1:0][15:0]     x_in;
      logic signed [1:0][AW-1:0]   comp_x1;
      logic signed [1:0][AW-1:0]   comp_y1;
      logic signed [1:0][15:0]     stage_x;
      logic signed [1:0][4:0][AW-1:0] bx1;
      logic signed [1:0][4:0][AW-1:0] bx2;
      logic signed [1:0][4:0][AW-1:0] by1;
      logic signed [1:0][4:0][AW-1:0] by2;
      logic signed [AW-1:0]        acc;
      logic signed [1:0][15:0]     result;
      logic                        out_valid;
      logic                        rec_path;
   } gceq_state_rec_t;

   gceq_state_rec_t st;
   gceq_state_rec_t next_st;

   logic        buf_in_ready;
   logic [31:0] buf_out_data;

   assign o_ready = (st.fsm == gceq_pkg::GCEQ_IDLE) && !st.out_valid;

   always_comb begin
      logic signed [AW-1:0] x;
      logic signed [AW-1:0] y;
      logic signed [AW-1:0] hb;
      logic signed [AW-1:0] g;
      int                   c;
      int                   b;
      x = '0;
      y = '0;
      hb = '0;
      g = '0;
      c = 0;
      b = 0;
      next_st = st;
      c = int'(st.ch);
      b = int'(st.band);
      next_st.rec_path = record_path(i_playback_filter_select,
                                     i_left_adc_power,
                                     i_right_adc_power);
      case (st.fsm)
         gceq_pkg::GCEQ_IDLE: begin
            if (st.out_valid && buf_in_ready) begin
               next_st.out_valid = 1'b0;
            end
            if (i_valid && o_ready) begin
               next_st.x_in[0] = i_left;
               next_st.x_in[1] = i_right;
               next_st.ch  = 1'b0;
               next_st.fsm = gceq_pkg::GCEQ_COMP;
            end
         end
         gceq_pkg::GCEQ_COMP: begin
            // Compensation stage sits right after the separation filter.
            x = sext16(st.x_in[c]);
            if (i_comp_eq_enable) begin
               y = comp_step(x,
                             st.comp_x1[c],
                             st.comp_y1[c],
                             i_comp_coef_a,
                             i_comp_coef_b,
                             i_comp_coef_c);
            end else begin
               y = x;
            end
            next_st.comp_x1[c] = x;
            next_st.comp_y1[c] = y;
            g = apply_gain(y, i_fixed_gain_select);
            next_st.stage_x[c] = clip16(g);
            next_st.acc  = sat16(g);
            next_st.band = 3'h0;
            next_st.fsm  = gceq_pkg::GCEQ_BAND;
         end
         gceq_pkg::GCEQ_BAND: begin
            // Each band keeps its own coefficients and history.
            x  = sext16(st.stage_x[c]);
            hb = band_step(x,
                           st.bx2[c][b],
                           st.by1[c][b],
                           st.by2[c][b],
                           i_band_coef_a[b],
                           i_band_coef_b[b],
                           i_band_coef_c[b]);
            next_st.bx2[c][b] = st.bx1[c][b];
            next_st.bx1[c][b] = x;
            next_st.by2[c][b] = st.by1[c][b];
            next_st.by1[c][b] = hb;
            if (i_band_enable[b]) begin
               next_st.acc = st.acc + hb;
            end
            // A disabled band leaves the sum untouched.
            if (b == gceq_pkg::NBANDS - 1) begin
               next_st.fsm = gceq_pkg::GCEQ_SUM;
            end else begin
               next_st.band = st.band + 3'h1;
            end
         end
         gceq_pkg::GCEQ_SUM: begin
            next_st.result[c] = clip16(st.acc);
            if (st.ch) begin
               next_st.fsm = gceq_pkg::GCEQ_OUT;
            end else begin
               next_st.ch  = 1'b1;
               next_st.fsm = gceq_pkg::GCEQ_COMP;
            end
         end
         gceq_pkg::GCEQ_OUT: begin
            next_st.out_valid = 1'b1;
            next_st.fsm = gceq_pkg::GCEQ_IDLE;
         end
         default: begin
            next_st.fsm = gceq_pkg::GCEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   //==============================================================
   // Output buffer.
   //==============================================================
   gceq_buffer #(
      .WIDTH (32),
      .DEPTH (2)
   ) u_buffer (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_valid   (st.out_valid),
      .o_ready   (buf_in_ready),
      .i_data    ({st.result[1], st.result[0]}),
      .o_valid   (o_valid),
      .i_ready   (i_ready),
      .o_data    (buf_out_data)
   );

   assign o_left           = buf_out_data[15:0];
   assign o_right          = buf_out_data[31:16];
   assign o_recording_path = st.rec_path;
   assign o_busy           = (st.fsm != gceq_pkg::GCEQ_IDLE);

endmodule : gceq_filter

//--- design/gceq_pkg.sv
//==============================================================
package gceq_pkg;

   localparam int DATA_W    = 16;
   localparam int COEF_W    = 16;
   localparam int COMP_B_W  = 14;
   localparam int FRAC_BITS = 13;
   localparam int NBANDS    = 5;
   localparam int ACC_W     = 40;

   localparam logic [1:0] GAIN_0DB  = 2'h0;
   localparam logic [1:0] GAIN_12DB = 2'h1;
   localparam int         SHIFT_12DB = 2;
   localparam int         SHIFT_24DB = 4;
   localparam logic [1:0] GAIN_RESET = 2'h0;

   typedef enum logic [2:0] {
      GCEQ_IDLE  = 3'h0,
      GCEQ_COMP  = 3'h1,
      GCEQ_BAND  = 3'h3,
      GCEQ_SUM   = 3'h2,
      GCEQ_OUT   = 3'h6
   } gceq_state_t;

endpackage : gceq_pkg

//--- design/gceq_buffer.sv
`timescale 1ns/1ns
module gceq_buffer #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
) (
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic [WIDTH-1:0]      o_data
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [$clog2(DEPTH+1)-1:0]  count;
   } gceq_buf_t;

   gceq_buf_t st;
   gceq_buf_t next_st;

   always_comb begin
      logic push;
      logic pop;
      push = 1'b0;
      pop  = 1'b0;
      next_st = st;
      pop  = o_valid && i_ready;
      push = i_valid && o_ready;
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            next_st.mem[i] = st.mem[i+1];
         end
      end
      if (push) begin
         next_st.mem[int'(st.count) - (pop ? 1 : 0)] = i_data;
      end
      next_st.count = st.count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_ready = (int'(st.count) < DEPTH);
   assign o_valid = (st.count != '0);
   assign o_data  = st.mem[0];

endmodule : gceq_buffer

//--- verification/gceq_filter_asserts.sv
`timescale 1ns/1ns
//==========
// Handshake, timing and path checks.
module gceq_filter_asserts (
   input wire logic               i_clk,
   input wire logic               i_reset_n,
   input wire logic               i_valid,
   input wire logic               o_ready,
   input wire logic               o_valid,
   input wire logic               i_ready,
   input wire logic signed [15:0] o_left,
   input wire logic signed [15:0] o_right,
   input wire logic               i_left_adc_power,
   input wire logic               i_right_adc_power,
   input wire logic               i_playback_filter_select,
   input wire logic               o_recording_path,
   input wire logic               o_busy
);
   wire logic take = i_valid && o_ready;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_busy_refuse: assert property (o_busy |-> !o_ready)
      else $error("ready while busy");
   a_work_len: assert property (take |=> o_busy[*8] ##1 o_busy[*7] ##1 !o_busy)
      else $error("busy length wrong");
   a_take_refuse: assert property (take |=> !o_ready[*8] ##1 !o_ready[*8])
      else $error("pair accepted too soon");
   a_out_latency: assert property (take && !o_valid |-> ##17 o_valid)
      else $error("result late");
   a_out_hold: assert property (o_valid && !i_ready |=>
      o_valid && $stable(o_left) && $stable(o_right)) else $error("result lost on stall");
   a_valid_src: assert property ($rose(o_valid) |-> $past(o_busy, 2))
      else $error("result without work");
   a_idle_ready: assert property ($fell(o_busy) && !o_valid |-> ##[0:2] o_ready)
      else $error("idle but not ready");
   a_path_sel: assert property ($past(i_reset_n) |-> o_recording_path ==
      $past(!i_playback_filter_select && (i_left_adc_power || i_right_adc_power)))
      else $error("path select wrong");
   c_take: cover property (take);
   c_refuse: cover property (o_valid && !i_ready && !o_ready);
   c_record: cover property (o_recording_path);
endmodule : gceq_filter_asserts

bind gceq_filter gceq_filter_asserts u_asserts (.i_clk, .i_reset_n, .i_valid, .o_ready,
   .o_valid, .i_ready, .o_left, .o_right, .i_left_adc_power, .i_right_adc_power,
   .i_playback_filter_select, .o_recording_path, .o_busy);

//--- verification/gain_comp_and_five_band_eq_tb_top.sv
`timescale 1ns/1ns
//==========
// Self-checking bench for the filter stage.
module gain_comp_and_five_band_eq_tb_top;
   logic clk = 0, rst_n = 0, iv = 0, rdy = 0, hold = 0, ce = 0, lp = 0, rp = 0, ps = 0;
   logic signed [15:0] il = 0, irt = 0, ol, orr;
   logic [15:0] ca = 0, cc = 0;
   logic [13:0] cb = 0;
   logic [1:0] gs = 0;
   logic [4:0] be = 0;
   logic [4:0][15:0] ba = 0, bb = 0, bc = 0;
   logic ov, ordy, busy, rec;
   logic [31:0] seed = 32'ha94d9183, rs = 32'ha94d9183;
   logic [31:0] q[$];
   int err_count = 0, checked = 0;
   longint xp[2], yp[2], x1[2], x2[2], h1[2][5], h2[2][5];
   always #25 clk = ~clk;
   gceq_filter dut (.i_clk(clk), .i_reset_n(rst_n), .i_valid(iv), .o_ready(ordy),
      .i_left(il), .i_right(irt), .o_valid(ov), .i_ready(rdy), .o_left(ol), .o_right(orr),
      .i_comp_eq_enable(ce), .i_comp_coef_a(ca), .i_comp_coef_b(cb), .i_comp_coef_c(cc),
      .i_fixed_gain_select(gs), .i_band_enable(be), .i_band_coef_a(ba), .i_band_coef_b(bb),
      .i_band_coef_c(bc), .i_left_adc_power(lp), .i_right_adc_power(rp),
      .i_playback_filter_select(ps), .o_recording_path(rec), .o_busy(busy));
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [15:0] sat(longint v);
      return (v > 32767) ? 16'h7fff : (v < -32768) ? 16'h8000 : v[15:0];
   endfunction : sat
   function automatic logic [15:0] model(int c, longint x);
      longint y, s, h;
      int k;
      y = ce ? (($signed(ca) * x) >>> 13) + (($signed(cc) * xp[c]) >>> 13)
         - (($signed(cb) * yp[c]) >>> 13) : x;
      xp[c] = x;
      yp[c] = y;
      y = $signed(sat(y * (gs[1] ? 16 : gs[0] ? 4 : 1)));
      s = y;
      for (k = 0; k < 5; k++) begin
         h = (($signed(ba[k]) * (y - x2[c])) >>> 13) + (($signed(bb[k]) * h1[c][k]) >>> 13)
            + (($signed(bc[k]) * h2[c][k]) >>> 13);
         h2[c][k] = h1[c][k];
         h1[c][k] = h;
         if (be[k]) s += h;
      end
      x2[c] = x1[c];
      x1[c] = y;
      return sat(s);
   endfunction : model
   task automatic finish_test();
      if (err_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic do_reset();
      rst_n = 0;
      xp = '{default: 0};
      yp = '{default: 0};
      x1 = '{default: 0};
      x2 = '{default: 0};
      h1 = '{default: 0};
      h2 = '{default: 0};
      repeat (5) @(posedge clk);
      #1 rst_n = 1;
   endtask : do_reset
   task automatic send(logic signed [15:0] l, logic signed [15:0] r);
      int n = 0;
      il = l;
      irt = r;
      iv = 1;
      q.push_back({model(0, l), model(1, r)});
      while (ordy !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1 n++;
      end
      if (n >= 400) begin
         err_count++;
         finish_test();
      end
      @(posedge clk);
      #1;
   endtask : send
   task automatic run(int n, int sh);
      int m = 0;
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         send($signed(seed[15:0]) >>> sh, $signed(seed[31:16]) >>> sh);
      end
      iv = 0;
      while (q.size() != 0 && m < 400) begin
         @(posedge clk);
         #1 m++;
      end
      if (m >= 400) begin
         err_count++;
         finish_test();
      end
   endtask : run
   always @(posedge clk) begin
      #1 rs = lfsr(rs);
      rdy = hold ? 1'b0 : rs[0] | rs[1];
   end
   always @(posedge clk)
      if (rst_n === 1'b1 && ov === 1'b1 && rdy === 1'b1) begin
         if (q.size() == 0) check("extra", 32'h0, 32'h1);
         else check("sample", q.pop_front(), {ol, orr});
      end
   initial begin
      do_reset();
      run(4, 0);
      hold = 1;
      for (int i = 0; i < 3; i++) send(16'h7fff - 16'(i), 16'h8000 + 16'(i));
      hold = 0;
      run(2, 0);
      for (int g = 1; g < 4; g++) begin
         gs = 2'(g);
         run(3, 0);
      end
      gs = 2'h0;
      do_reset();
      ca = 16'h2000;
      cc = 16'h2000;
      cb = 14'h2000;
      ce = 1;
      run(4, 6);
      ce = 0;
      for (int k = 0; k < 5; k++) begin
         ba[k] = k[0] ? 16'he000 : 16'h2000;
         bb[k] = (k < 3) ? 16'h2000 : 16'h0;
         bc[k] = (k == 1) ? 16'he000 : 16'h0;
      end
      for (int k = 0; k < 6; k++) begin
         do_reset();
         be = (k == 5) ? 5'h1f : 5'h1 << k;
         run(4, 6);
      end
      for (int i = 0; i < 8; i++) begin
         {lp, rp, ps} = 3'(i);
         @(posedge clk);
         #1 check("path", {31'h0, !ps && (lp || rp)}, {31'h0, rec});
      end
      finish_test();
   end
endmodule : gain_comp_and_five_band_eq_tb_top
